/* dbab_autobaud.v */
`timescale 1ns/1ps
// Operation
// - After reset the port is idle, sending nothing and taking no data, until the line goes low.
// - The low run of start bit plus seven low data bits is timed and programs the bit period.
// - Measurement and bit timing both count system clock cycles.
// - Bit periods up to 512 system clocks are supported.
// - Bit periods down to four system clocks work on a clean line.
// - Characters are one start bit, eight data bits LSB first, one stop bit.
`include "dbab_map.vh"
module dbab_autobaud (
  // Clock and reset
  input  wire                  clk_sys,
  input  wire                  rst_n,
  // Debug serial line
  input  wire                  dbg_rx,
  output reg                   dbg_tx,
  output reg                   dbg_tx_oe,
  // Received data to debugger core
  output reg  [7:0]            rx_data,
  output reg                   rx_valid,
  output reg                   rx_frame_err,
  // Transmit data from debugger core
  input  wire [7:0]            tx_data,
  input  wire                  tx_start,
  output reg                   tx_busy,
  // Status
  output reg                   baud_locked,
  output reg                   baud_err,
  output reg  [`DBAB_DIV_W:0]  bit_period
);
  localparam ST_IDLE = 3'h0;
  localparam ST_MEAS = 3'h1;
  localparam ST_WAIT = 3'h2;
  localparam ST_RDY  = 3'h3;
  localparam ST_RX   = 3'h4;
  localparam ST_ERR  = 3'h5;

  // ----------------------------------------
  // Line synchroniser
  // ----------------------------------------
  reg rx_meta;
  reg rx_s;
  reg rx_d;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
      rx_d    <= 1'b1;
    end else begin
      rx_meta <= dbg_rx;
      rx_s    <= rx_meta;
      rx_d    <= rx_s;
    end
  end
  // Idle-high reset values keep a false edge out after reset
  wire rx_fall = rx_d & ~rx_s;

  // ----------------------------------------
  // Autobaud measurement and receiver
  // ----------------------------------------
  reg [2:0]              state;
  reg [`DBAB_MEAS_W-1:0] meas;
  reg [3:0]              rx_bit;
  reg [7:0]              rx_shift;
  wire                   rx_mid;
  wire                   rx_restart = (state == ST_RDY) && rx_fall;

  // Divides the low run by eight with rounding for a tolerant period
  function [`DBAB_DIV_W:0] period_of;
    input [`DBAB_MEAS_W-1:0] m;
    reg   [`DBAB_MEAS_W-1:0] r;
    begin
      r = m + `DBAB_MEAS_ROUND;
      period_of = r[`DBAB_MEAS_W-1:3];
    end
  endfunction

  // Run under 4 clocks per bit, or over 512 after rounding
  function rate_bad;
    input [`DBAB_MEAS_W-1:0] m;
    begin
      rate_bad = (m > `DBAB_MEAS_HI) || (m < `DBAB_MEAS_LO);
    end
  endfunction

  // Stop bit position, shared by receiver and transmitter
  function last_bit;
    input [3:0] n;
    begin
      last_bit = (n == `DBAB_FRAME_BITS - 4'h1);
    end
  endfunction

  dbab_bit_timer u_rx_timer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .restart  (rx_restart),
    .period   (bit_period),
    .mid_tick (rx_mid),
    .end_tick ()
  );

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      meas         <= {`DBAB_MEAS_W{1'b0}};
      rx_bit       <= 4'h0;
      rx_shift     <= 8'h00;
      rx_data      <= 8'h00;
      rx_valid     <= 1'b0;
      rx_frame_err <= 1'b0;
      baud_locked  <= 1'b0;
      baud_err     <= 1'b0;
      bit_period   <= `DBAB_MAX_BIT_CLKS;
    end else begin
      rx_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Nothing happens until the host's first falling edge
          if (rx_fall) begin
            meas  <= `DBAB_MEAS_START;
            state <= ST_MEAS;
          end
        end
        ST_MEAS: begin
          // Low run of start plus seven zero bits of 80H, timed in clk_sys
          if (!rx_s) begin
            if (meas != `DBAB_MEAS_MAX)
              meas <= meas + 1'b1;
          end else if (rate_bad(meas)) begin
            baud_err <= 1'b1;
            state    <= ST_ERR;
          end else begin
            bit_period  <= period_of(meas);
            baud_locked <= 1'b1;
            state       <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Sync char's high D7 and stop bit still to come; no edge falls here
          state <= ST_RDY;
        end
        ST_RDY: begin
          // Timer restarts on the same edge so mid-bit samples land centred
          if (rx_fall) begin
            rx_bit <= 4'h0;
            state  <= ST_RX;
          end
        end
        ST_RX: begin
          // Bit 0 rechecks the start bit to reject glitches
          if (rx_mid) begin
            rx_bit <= rx_bit + 1'b1;
            if (rx_bit == 4'h0) begin
              if (rx_s)
                state <= ST_RDY;
            end else if (last_bit(rx_bit)) begin
              rx_data      <= rx_shift;
              rx_valid     <= rx_s;
              rx_frame_err <= ~rx_s;
              state        <= ST_RDY;
            end else begin
              rx_shift <= {rx_s, rx_shift[7:1]};
            end
          end
        end
        ST_ERR: begin
          // Bad rate stays locked out until the next reset
          state <= ST_ERR;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Transmitter, shares the measured period
  // ----------------------------------------
  reg [9:0] tx_shift;
  reg [3:0] tx_cnt;
  wire      tx_end;
  // Requests while busy or unlocked are dropped, not queued
  wire      tx_go = tx_start && !tx_busy && baud_locked;

  dbab_bit_timer u_tx_timer (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .restart  (tx_go),
    .period   (bit_period),
    .mid_tick (),
    .end_tick (tx_end)
  );

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_shift  <= 10'h3ff;
      tx_cnt    <= 4'h0;
      tx_busy   <= 1'b0;
      dbg_tx    <= 1'b1;
      dbg_tx_oe <= 1'b0;
    end else begin
      // Drive only once locked, so the line stays released while idle
      dbg_tx_oe <= baud_locked;
      if (tx_go) begin
        tx_shift <= {1'b1, tx_data, 1'b0};
        tx_cnt   <= 4'h0;
        tx_busy  <= 1'b1;
        dbg_tx   <= 1'b0;
      end else if (tx_busy && tx_end) begin
        if (last_bit(tx_cnt)) begin
          tx_busy <= 1'b0;
          dbg_tx  <= 1'b1;
        end else begin
          tx_cnt   <= tx_cnt + 1'b1;
          dbg_tx   <= tx_shift[1];
          tx_shift <= {1'b1, tx_shift[9:1]};
        end
      end
    end
  end
endmodule

/* dbab_map.vh */
`ifndef DBAB_MAP_VH
`define DBAB_MAP_VH
// ----------------------------------------
// Debug autobaud constants
// ----------------------------------------
`define DBAB_SYNC_CHAR    8'h80
`define DBAB_LOW_BITS     4'h8
`define DBAB_MAX_BIT_CLKS 10'h200
`define DBAB_MIN_BIT_CLKS 10'h004
`define DBAB_MEAS_W       13
`define DBAB_DIV_W        9
`define DBAB_MEAS_MAX     13'h1fff
`define DBAB_MEAS_START   13'h0001
`define DBAB_MEAS_ROUND   13'h0004
// Low run limits: 4 x 8, and the longest run that still rounds to 512
`define DBAB_MEAS_LO      13'h0020
`define DBAB_MEAS_HI      13'h1003
`define DBAB_FRAME_BITS   4'ha
`endif

/* dbab_bit_timer.v */
`timescale 1ns/1ps
// ----------------------------------------
// Bit period timer: mid-bit and end-bit pulses
// ----------------------------------------
`include "dbab_map.vh"
module dbab_bit_timer (
  // Clock and reset
  input  wire                  clk_sys,
  input  wire                  rst_n,
  // Control
  input  wire                  restart,
  input  wire [`DBAB_DIV_W:0]  period,
  // Ticks
  output reg                   mid_tick,
  output reg                   end_tick
);
  reg [`DBAB_DIV_W:0] cnt;
  wire [`DBAB_DIV_W:0] half = {1'b0, period[`DBAB_DIV_W:1]};

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= {(`DBAB_DIV_W+1){1'b0}};
      mid_tick <= 1'b0;
      end_tick <= 1'b0;
    end else if (restart) begin
      // Starts at one: registered ticks would stretch the first bit by a clock
      cnt      <= {{`DBAB_DIV_W{1'b0}}, 1'b1};
      mid_tick <= 1'b0;
      end_tick <= 1'b0;
    end else begin
      mid_tick <= (cnt == half - 1'b1);
      end_tick <= (cnt == period - 1'b1);
      if (cnt == period - 1'b1)
        cnt <= {(`DBAB_DIV_W+1){1'b0}};
      else
        cnt <= cnt + 1'b1;
    end
  end
endmodule

/* dbab_autobaud_checker.sv */
`timescale 1ns/1ps
`include "dbab_map.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module dbab_autobaud_checker (
  input logic                 clk_sys,
  input logic                 rst_n,
  input logic                 dbg_tx,
  input logic                 dbg_tx_oe,
  input logic                 rx_valid,
  input logic                 tx_busy,
  input logic                 baud_locked,
  input logic                 baud_err,
  input logic [`DBAB_DIV_W:0] bit_period
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_idle_no_drive: assert property (!baud_locked |-> !dbg_tx_oe && dbg_tx)
    else $error("line driven before lock");
  a_idle_no_rx: assert property (!baud_locked |-> !rx_valid)
    else $error("byte delivered before lock");
  a_lock_holds: assert property (baud_locked |=> baud_locked && $stable(bit_period))
    else $error("lock or period changed");
  a_period_range: assert property (baud_locked |-> bit_period >= 4 && bit_period <= 512)
    else $error("period out of range");
  a_start_low: assert property ($rose(tx_busy) |-> !dbg_tx [*4])
    else $error("start bit too short");
  a_busy_locked: assert property (tx_busy |-> baud_locked && dbg_tx_oe)
    else $error("sending without lock");
  a_stop_high: assert property ($fell(tx_busy) |-> dbg_tx && $past(dbg_tx))
    else $error("stop bit not high");
  a_tx_idle_high: assert property (!tx_busy |-> dbg_tx)
    else $error("idle line not high");
  a_err_no_lock: assert property (baud_err |-> !baud_locked)
    else $error("locked despite rate error");
endmodule

/* dbab_host.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Debug host adapter model
// ----------------------------------------
module dbab_host (
  input  logic clk_sys,
  input  logic line_tx,
  output logic dbg_rx
);
  initial dbg_rx = 1'b1;
  // Period in clocks; callers stay at or above 4 except range tests
  task automatic send(input logic [7:0] b, input int p, input logic s = 1'b1);
    logic [9:0] f;
    f = {s, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      dbg_rx <= f[i];
      repeat (p) @(posedge clk_sys);
    end
    dbg_rx <= 1'b1;
  endtask
  task automatic recv(output logic [7:0] b, input int p);
    while (line_tx) @(posedge clk_sys) #1;
    repeat (p / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (p) @(posedge clk_sys);
      b[i] = line_tx;
    end
    repeat (p) @(posedge clk_sys);
  endtask
endmodule

/* tb_debug_autobaud_detector.sv */
`timescale 1ns/1ps
`include "dbab_map.vh"
module tb_debug_autobaud_detector;
  logic clk_sys = 0, rst_n = 0, dbg_rx, tx_start = 0;
  logic dbg_tx, dbg_tx_oe, rx_valid, rx_frame_err, tx_busy, baud_locked, baud_err;
  logic [7:0] rx_data, tx_data = 8'h00, got;
  logic [`DBAB_DIV_W:0] bit_period;
  int err_total = 0, checks = 0;
  wire line_tx = dbg_tx_oe ? dbg_tx : 1'b1;
  dbab_host h (.clk_sys, .line_tx, .dbg_rx);
  dbab_autobaud u_dut (.clk_sys, .rst_n, .dbg_rx, .dbg_tx, .dbg_tx_oe, .rx_data, .rx_valid,
    .rx_frame_err, .tx_data, .tx_start, .tx_busy, .baud_locked, .baud_err, .bit_period);
  initial forever #25 clk_sys = ~clk_sys;
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic lock(int p);
    @(posedge clk_sys);
    rst_n <= 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    repeat (20) @(posedge clk_sys);
    #1;
    chk("oe idle", 0, dbg_tx_oe);
    chk("period reset", 512, bit_period);
    @(posedge clk_sys);
    h.send(8'h80, p);
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_lock(int p);
    lock(p);
    chk("locked", 1, baud_locked);
    chk("period", p, bit_period);
    chk("oe locked", 1, dbg_tx_oe);
    chk("no err", 0, baud_err);
    $display("test lock %0d done", p);
  endtask
  task automatic t_range(int p);
    lock(p);
    chk("range err", 1, baud_err);
    chk("no lock", 0, baud_locked);
    $display("test range %0d done", p);
  endtask
  task automatic t_rx(logic [7:0] b, logic s);
    int n;
    @(posedge clk_sys);
    fork
      h.send(b, 8, s);
      begin
        for (n = 0; n < 200 && rx_valid !== 1; n++) @(posedge clk_sys) #1;
        chk("rx valid", s, rx_valid);
      end
    join
    chk("rx data", b, rx_data);
    chk("frame err", !s, rx_frame_err);
    $display("test rx done");
  endtask
  task automatic t_tx(logic [7:0] b);
    @(posedge clk_sys);
    fork
      h.recv(got, 8);
      begin
        #1;
        while (tx_busy) @(posedge clk_sys) #1;
        @(posedge clk_sys);
        tx_data <= b;
        tx_start <= 1;
        @(posedge clk_sys);
        tx_start <= 0;
      end
    join
    chk("tx data", b, got);
    $display("test tx done");
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    results();
  end
  initial begin
    t_lock(4);
    t_lock(512);
    t_range(3);
    t_range(600);
    t_lock(8);
    t_rx(8'ha5, 1);
    t_rx(8'h5a, 0);
    t_rx(8'h01, 1);
    t_tx(8'h3c);
    t_tx(8'h81);
    results();
  end
endmodule
bind dbab_autobaud dbab_autobaud_checker u_chk (.clk_sys, .rst_n, .dbg_tx, .dbg_tx_oe,
  .rx_valid, .tx_busy, .baud_locked, .baud_err, .bit_period);
